// ==== core/ifd_decoder.sv ====
// Contract
// - Code 4 rising edge commands servo on, falling edge servo off, transitions spaced at least 1.5 s.
// - Code 5 rising edge starts the auto-start program, falling edge aborts all but the abort I/O program.
// - Code 6 low is a soft interlock when no servo-off is active: hold in auto, abort otherwise.
// - Code 7 rising edge clears a pending pause.
// - Code 8 low pauses operation in auto mode only, latched until pause reset.
// - Codes 9 to 15 are program number bits weighted 1..64 binary or 1,2,4,8,10,20,40 BCD.
// - Number bits must be contiguous from the LSB in ascending order, else rejected.
// - Code 17 rising edge resets drive cutoff only once its cause is gone.
// - Cutoff control skips axes whose power or cutoff circuit the controller does not own.
// - Code 18 rising edge commands home return of all valid axes.
// - Home return is acted on only with the servo on.
// - Code 0 leaves a port as a general-purpose input.
// - Codes 1 and 2 start the selected program in BCD or binary, never both assigned.
`timescale 1ns/1ps
module ifd_decoder
  import ifd_pkg::*;
#(
  parameter int PORTS = 16,
  parameter int AXES = 4,
  parameter longint SERVO_GAP_CYC = IFD_SERVO_GAP_CYC
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [PORTS-1:0] port_in,
  input wire logic [PORTS*IFD_FN_W-1:0] func_in,
  input wire logic auto_mode_in,
  input wire logic cut_cause_in,
  input wire logic [AXES-1:0] axis_valid_in,
  input wire logic [AXES-1:0] axis_cut_own_in,
  output logic [AXES-1:0] servo_on_out,
  output ifd_cmd_type cmd_out,
  output ifd_stat_type stat_out,
  output logic [6:0] prog_num_out,
  output logic [AXES-1:0] home_axes_out,
  output logic [AXES-1:0] cut_axes_out,
  output logic [PORTS-1:0] gp_level_out
);
  localparam int GAP_W = $clog2(SERVO_GAP_CYC + 1);

  logic [PORTS-1:0] lvl, prev_q;
  logic [PORTS-1:0] rise, fall;
  ifd_cmd_type cmd_d, cmd_q;
  ifd_stat_type stat_d, stat_q;
  logic [6:0] prog_d, prog_q;
  logic [AXES-1:0] servo_d, servo_q, home_d, home_q, cutax_d, cutax_q;
  logic [PORTS-1:0] gp_d, gp_q;
  logic [GAP_W-1:0] gap_d, gap_q;
  logic want_on_d, want_on_q;

  // Function code of one port
  function automatic logic [IFD_FN_W-1:0] fn_of(
    input logic [PORTS*IFD_FN_W-1:0] f, input int p);
    fn_of = f[p*IFD_FN_W +: IFD_FN_W];
  endfunction : fn_of

  // Weight of a number bit in BCD or binary
  function automatic logic [6:0] bit_wt(input int b, input logic bcd);
    logic [6:0] w;
    w = 7'(1 << b);
    if (bcd && b >= 4) begin
      w = 7'(10 << (b - 4));
    end
    bit_wt = w;
  endfunction : bit_wt

  ifd_sync #(.WIDTH(PORTS)) u_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .raw_in(port_in),
    .level_out(lvl)
  );

  assign rise = lvl & ~prev_q;
  assign fall = ~lvl & prev_q;

  // Decode of ports into commands and levels
  always_comb begin
    logic [IFD_PBITS-1:0] have, pval;
    logic bcd, bin, il_low, pause_low, cfg_bad, start_e, cause_gone;
    logic [6:0] n;
    have = '0;
    pval = '0;
    bcd = 1'b0;
    bin = 1'b0;
    il_low = 1'b0;
    pause_low = 1'b0;
    cfg_bad = 1'b0;
    start_e = 1'b0;
    n = '0;
    cause_gone = ~cut_cause_in;
    cmd_d = '0;
    gp_d = '0;
    home_d = '0;
    cutax_d = cutax_q;
    stat_d = stat_q;
    servo_d = servo_q;
    want_on_d = want_on_q;
    gap_d = (gap_q != '0) ? gap_q - 1'b1 : gap_q;
    for (int p = 0; p < PORTS; p++) begin
      case (fn_of(func_in, p))
        IFD_FN_GENERAL: gp_d[p] = lvl[p];
        IFD_FN_START_BCD: begin
          bcd = 1'b1;
          start_e |= rise[p];
        end
        IFD_FN_START_BIN: begin
          bin = 1'b1;
          start_e |= rise[p];
        end
        IFD_FN_SERVO: begin
          if (rise[p]) want_on_d = 1'b1;
          if (fall[p]) want_on_d = 1'b0;
        end
        IFD_FN_AUTO_START: begin
          cmd_d.auto_start |= rise[p];
          cmd_d.abort_all |= fall[p];
        end
        IFD_FN_INTERLOCK: il_low |= ~lvl[p];
        IFD_FN_PAUSE_RST: cmd_d.pause_clear |= rise[p];
        IFD_FN_PAUSE: pause_low |= ~lvl[p];
        IFD_FN_ERR_RST: cmd_d.err_clear |= rise[p];
        IFD_FN_CUT_RST: cmd_d.cut_reset |= rise[p] & cause_gone;
        IFD_FN_HOME: cmd_d.home |= rise[p] & (servo_q != '0);
        default: begin
          if (fn_of(func_in, p) >= IFD_FN_PBIT_LO &&
              fn_of(func_in, p) <= IFD_FN_PBIT_HI) begin
            for (int b = 0; b < IFD_PBITS; b++) begin
              if (fn_of(func_in, p) == IFD_FN_PBIT_LO + 7'(b)) begin
                cfg_bad |= have[b];
                have[b] = 1'b1;
                pval[b] = lvl[p];
              end
            end
          end
        end
      endcase
    end
    // Number bits must fill from the LSB upward
    for (int b = 1; b < IFD_PBITS; b++) begin
      cfg_bad |= have[b] & ~have[b-1];
    end
    cfg_bad |= bcd & bin;
    for (int b = 0; b < IFD_PBITS; b++) begin
      if (pval[b]) n = n + bit_wt(b, bcd);
    end
    stat_d.cfg_error = cfg_bad;
    if (start_e && !cfg_bad) begin
      cmd_d.prog_start = 1'b1;
      prog_d = n;
    end else begin
      prog_d = prog_q;
    end
    // Servo edges spaced by the minimum gap
    if (gap_q == '0 && want_on_d != stat_q.servo_on) begin
      cmd_d.servo_on = want_on_d;
      cmd_d.servo_off = ~want_on_d;
      stat_d.servo_on = want_on_d;
      servo_d = want_on_d ? axis_valid_in : '0;
      gap_d = GAP_W'(SERVO_GAP_CYC);
    end
    // Interlock only while servo-off is not commanded
    stat_d.hold = il_low & stat_q.servo_on & auto_mode_in;
    stat_d.abort_il = il_low & stat_q.servo_on & ~auto_mode_in;
    // Pause latches in auto, clears on reset edge
    if (pause_low && auto_mode_in) begin
      stat_d.paused = 1'b1;
    end else if (cmd_d.pause_clear) begin
      stat_d.paused = 1'b0;
    end
    // Drive cutoff only on owned axes
    if (cut_cause_in) begin
      stat_d.cutoff = 1'b1;
      cutax_d = axis_valid_in & axis_cut_own_in;
    end else if (cmd_d.cut_reset) begin
      stat_d.cutoff = 1'b0;
      cutax_d = '0;
    end
    if (cmd_d.home) home_d = axis_valid_in & servo_q;
  end

  // State registers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prev_q <= '0;
      cmd_q <= '0;
      stat_q <= '0;
      prog_q <= '0;
      servo_q <= '0;
      home_q <= '0;
      cutax_q <= '0;
      gp_q <= '0;
      gap_q <= '0;
      want_on_q <= 1'b0;
    end else begin
      prev_q <= lvl;
      cmd_q <= cmd_d;
      stat_q <= stat_d;
      prog_q <= prog_d;
      servo_q <= servo_d;
      home_q <= home_d;
      cutax_q <= cutax_d;
      gp_q <= gp_d;
      gap_q <= gap_d;
      want_on_q <= want_on_d;
    end
  end

  assign servo_on_out = servo_q;
  assign cmd_out = cmd_q;
  assign stat_out = stat_q;
  assign prog_num_out = prog_q;
  assign home_axes_out = home_q;
  assign cut_axes_out = cutax_q;
  assign gp_level_out = gp_q;
endmodule : ifd_decoder

// ==== core/ifd_pkg.sv ====
package ifd_pkg;
  // Input function codes
  localparam logic [6:0] IFD_FN_GENERAL = 7'h00;
  localparam logic [6:0] IFD_FN_START_BCD = 7'h01;
  localparam logic [6:0] IFD_FN_START_BIN = 7'h02;
  localparam logic [6:0] IFD_FN_SERVO = 7'h04;
  localparam logic [6:0] IFD_FN_AUTO_START = 7'h05;
  localparam logic [6:0] IFD_FN_INTERLOCK = 7'h06;
  localparam logic [6:0] IFD_FN_PAUSE_RST = 7'h07;
  localparam logic [6:0] IFD_FN_PAUSE = 7'h08;
  localparam logic [6:0] IFD_FN_PBIT_LO = 7'h09;
  localparam logic [6:0] IFD_FN_PBIT_HI = 7'h0F;
  localparam logic [6:0] IFD_FN_ERR_RST = 7'h10;
  localparam logic [6:0] IFD_FN_CUT_RST = 7'h11;
  localparam logic [6:0] IFD_FN_HOME = 7'h12;
  localparam int IFD_PBITS = 7;
  localparam int IFD_FN_W = 7;

  // Servo transition spacing
  localparam int IFD_CLK_HZ = 100_000_000;
  localparam int IFD_SERVO_GAP_MS = 1500;
  localparam longint IFD_SERVO_GAP_CYC =
    longint'(IFD_SERVO_GAP_MS) * longint'(IFD_CLK_HZ) / 64'd1000;

  // Decoded command pulses
  typedef struct packed {
    logic servo_on;
    logic servo_off;
    logic prog_start;
    logic auto_start;
    logic abort_all;
    logic pause_clear;
    logic err_clear;
    logic cut_reset;
    logic home;
  } ifd_cmd_type;

  // Decoded levels
  typedef struct packed {
    logic hold;
    logic abort_il;
    logic paused;
    logic servo_on;
    logic cutoff;
    logic cfg_error;
  } ifd_stat_type;
endpackage : ifd_pkg

// ==== core/ifd_sync.sv ====
`timescale 1ns/1ps
module ifd_sync
  import ifd_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, level_q;
  logic [WIDTH-1:0] level_d;

  // Change accepted when second and third stage agree
  always_comb begin
    level_d = level_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        level_d[i] = s3_q[i];
      end
    end
  end

  // Three-stage capture chain
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;
endmodule : ifd_sync

// ==== verification/ifd_decoder_assertions.sv ====
`timescale 1ns/1ps
module ifd_decoder_assertions
  import ifd_pkg::*;
#(
  parameter int AXES = 4,
  parameter int GAP = 20
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic auto_mode_in,
  input wire logic cut_cause_in,
  input wire logic [AXES-1:0] axis_valid_in,
  input wire logic [AXES-1:0] axis_cut_own_in,
  input wire ifd_cmd_type cmd_out,
  input wire ifd_stat_type stat_out,
  input wire logic [AXES-1:0] home_axes_out,
  input wire logic [AXES-1:0] cut_axes_out
);
  int gap_q;
  int gap_d;
  // Cycles since the last servo command
  always_comb begin
    gap_d = (cmd_out.servo_on || cmd_out.servo_off) ? 0 : gap_q + 1;
  end
  always_ff @(posedge clock_in) begin
    gap_q <= sys_rst_in ? GAP : gap_d;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  chk_servo_excl: assert property (
    !(cmd_out.servo_on && cmd_out.servo_off)) else $error("servo clash");
  chk_servo_gap: assert property (
    cmd_out.servo_on || cmd_out.servo_off |-> gap_q >= GAP - 1)
    else $error("servo gap short");
  chk_home_servo: assert property (
    cmd_out.home |-> stat_out.servo_on) else $error("home with servo off");
  chk_home_mask: assert property (
    home_axes_out == (cmd_out.home ? axis_valid_in : '0))
    else $error("home mask wrong");
  chk_cut_own: assert property (
    (cut_axes_out & ~axis_cut_own_in) == '0) else $error("cut axis foreign");
  chk_cut_block: assert property (
    cut_cause_in && $past(cut_cause_in) |-> !cmd_out.cut_reset)
    else $error("cut reset with cause");
  chk_pause_auto: assert property (
    $rose(stat_out.paused) |-> $past(auto_mode_in))
    else $error("pause outside auto");
  chk_prog_cfg: assert property (
    cmd_out.prog_start |-> !stat_out.cfg_error) else $error("start on bad cfg");
endmodule : ifd_decoder_assertions
bind ifd_decoder ifd_decoder_assertions #(
  .AXES(AXES), .GAP(int'(SERVO_GAP_CYC))) u_chk (
  .clock_in, .sys_rst_in, .auto_mode_in, .cut_cause_in, .axis_valid_in,
  .axis_cut_own_in, .cmd_out, .stat_out, .home_axes_out, .cut_axes_out);

// ==== verification/ifd_host_model.sv ====
`timescale 1ns/1ps
module ifd_host_model (
  input wire logic clock_in,
  input wire logic [16:0] want_in,
  output logic [16:0] port_out
);
  // Pins follow the sequencer request just after each edge
  initial port_out = 17'h00000;
  always @(posedge clock_in) port_out <= #1 want_in;
endmodule : ifd_host_model

// ==== verification/input_function_decoder_tb_top.sv ====
`timescale 1ns/1ps
module input_function_decoder_tb_top;
  import ifd_pkg::*;
  logic clock_in = 0, sys_rst_in = 1, auto_mode_in = 0, cut_cause_in = 0;
  logic [16:0] want = 17'h00014, port_in, gp_level_out;
  logic [118:0] func_in;
  logic [3:0] axis_valid_in = 4'hB, axis_cut_own_in = 4'h6;
  logic [3:0] servo_on_out, home_axes_out, cut_axes_out;
  logic [6:0] prog_num_out, n;
  ifd_cmd_type cmd_out;
  ifd_stat_type stat_out;
  int fails = 0, check_count = 0, seed = 51573;
  // Free running clock
  initial forever #5 clock_in = ~clock_in;
  ifd_host_model host (.clock_in, .want_in(want), .port_out(port_in));
  ifd_decoder #(.PORTS(17), .AXES(4), .SERVO_GAP_CYC(20)) uut (
    .clock_in, .sys_rst_in, .port_in, .func_in, .auto_mode_in, .cut_cause_in,
    .axis_valid_in, .axis_cut_own_in, .servo_on_out, .cmd_out, .stat_out,
    .prog_num_out, .home_axes_out, .cut_axes_out, .gp_level_out);
  task automatic conclude();
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clock_in);
      #1;
    end
  endtask : tick
  // Moves one pin, then watches one command bit for a bounded time
  task automatic pin(input int p, input logic v, input int b, input logic e);
    logic seen;
    seen = 0;
    want[p] = v;
    for (int i = 0; i < 40 && !(seen && e); i++) begin
      tick(1);
      seen |= cmd_out[b];
    end
    chk("cmd", {6'h00, e}, {6'h00, seen});
    if (seen !== e) conclude();
  endtask : pin
  // Program number from the number bits
  function automatic logic [6:0] pnum(input logic [6:0] b, input logic bcd);
    return bcd ? {3'h0, b[3:0]} + b[4] * 7'h0A + b[5] * 7'h14 + b[6] * 7'h28 : b;
  endfunction : pnum
  initial begin
    func_in = {7'h02, 7'h00, 7'h12, 7'h11, 7'h10, 7'h0F, 7'h0E, 7'h0D,
      7'h0C, 7'h0B, 7'h0A, 7'h09, 7'h08, 7'h07, 7'h06, 7'h05, 7'h04};
    tick(20);
    sys_rst_in = 0;
    chk("stat", 7'h00, {1'b0, stat_out});
    pin(14, 1, 0, 0);
    want[14] = 0;
    pin(0, 1, 8, 1);
    pin(0, 0, 7, 1);
    chk("servo", 7'h00, {3'h0, servo_on_out});
    pin(0, 1, 8, 1);
    tick(2);
    chk("servo", {3'h0, axis_valid_in}, {3'h0, servo_on_out});
    pin(14, 1, 0, 1);
    chk("home", 7'h0B, {3'h0, home_axes_out});
    pin(14, 0, 0, 0);
    want[2] = 0;
    tick(10);
    chk("abort", 7'h01, {6'h00, stat_out.abort_il});
    auto_mode_in = 1;
    tick(2);
    chk("hold", 7'h01, {6'h00, stat_out.hold});
    want[2] = 1;
    want[4] = 0;
    tick(10);
    want[4] = 1;
    tick(10);
    chk("pause", 7'h01, {6'h00, stat_out.paused});
    pin(3, 1, 3, 1);
    tick(2);
    chk("pause", 7'h00, {6'h00, stat_out.paused});
    for (int i = 0; i < 6; i++) begin
      n = (i == 5) ? 7'h7F : 7'($random(seed));
      func_in[118:112] = i[0] ? 7'h01 : 7'h02;
      want[11:5] = n;
      pin(16, 1, 6, 1);
      chk("prog", pnum(n, i[0]), prog_num_out);
      want[16] = 0;
      tick(8);
    end
    want[15] = n[0];
    tick(8);
    chk("gp", {6'h00, n[0]}, {6'h00, gp_level_out[15]});
    // Both start codes assigned at once is a bad set-up
    func_in[111:105] = 7'h02;
    tick(2);
    chk("cfg", 7'h01, {6'h00, stat_out.cfg_error});
    func_in[111:105] = 7'h00;
    tick(2);
    chk("cfg", 7'h00, {6'h00, stat_out.cfg_error});
    func_in[55:49] = 7'h0A;
    tick(8);
    chk("cfg", 7'h01, {6'h00, stat_out.cfg_error});
    pin(16, 1, 6, 0);
    want[16] = 0;
    func_in[55:49] = 7'h0B;
    pin(12, 1, 2, 1);
    cut_cause_in = 1;
    tick(4);
    chk("cut", 7'h01, {6'h00, stat_out.cutoff});
    chk("cut axes", 7'h02, {3'h0, cut_axes_out});
    pin(13, 1, 1, 0);
    want[13] = 0;
    cut_cause_in = 0;
    tick(8);
    pin(13, 1, 1, 1);
    tick(2);
    chk("cut", 7'h00, {6'h00, stat_out.cutoff});
    chk("cut axes", 7'h00, {3'h0, cut_axes_out});
    pin(1, 1, 5, 1);
    pin(1, 0, 4, 1);
    conclude();
  end
endmodule : input_function_decoder_tb_top
